// [hdl/uart_ifc.sv]
`timescale 1ns/100ps
module uart_ifc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic flush_i, // clear pointers
  input wire logic in_valid_i, // write request
  input wire logic [W-1:0] in_data_i, // write data
  output logic in_ready_o, // not full
  output logic out_valid_o, // not empty
  output logic [W-1:0] out_data_o, // head word
  input wire logic out_ready_i, // pop
  output logic [CW-1:0] count_o // fill level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;
  logic [CW-1:0] next_count;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rp];

  always_comb begin
    next_count = count_o;
    if (push & ~pop) begin
      next_count = count_o + 1'b1;
    end else if (pop & ~push) begin
      next_count = count_o - 1'b1;
    end
  end

  // Pointers wrap, so depth must be a power of two
  always_ff @(posedge sys_clk_i) begin
    if (rst_i | flush_i) begin
      wp <= '0;
      rp <= '0;
      count_o <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      count_o <= next_count;
      in_ready_o <= next_count != CW'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
endmodule : uart_ifc_fifo

module uart_ifc #(
  parameter int DEPTH = 32,
  parameter int GPIO_N = 4
) (
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic [3:0] reg_addr_i, // register address
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_wdata_i, // write data
  output logic [7:0] reg_rdata_o, // read data
  output logic reg_rvalid_o, // read data valid
  input wire logic [7:0] rx_data_i, // received char
  input wire logic [2:0] rx_err_i, // break, framing, parity
  input wire logic rx_valid_i, // char strobe
  output logic rx_ready_o, // receive space
  output logic [7:0] tx_data_o, // char to send
  output logic tx_valid_o, // char offered
  input wire logic tx_ready_i, // transmitter takes
  input wire logic tx_idle_i, // shift register empty
  output logic thr_ready_o, // transmit space
  input wire logic rs485_auto_i, // auto direction mode
  input wire logic bit_tick_i, // one per bit time
  input wire logic [3:0] modem_lines_i, // modem line states
  input wire logic [3:0] modem_delta_i, // modem change pulses
  input wire logic cts_n_i, // CTS pin
  input wire logic rts_n_i, // RTS drive level
  input wire logic [GPIO_N-1:0] gpio_i, // input pins
  input wire logic xoff_det_i, // Xoff seen
  input wire logic xon_det_i, // Xon seen
  input wire logic spchar_det_i, // special char seen
  output logic sleep_en_o, // sleep allowed
  output logic fifo_en_o, // FIFOs enabled
  output logic [1:0] word_len_o, // word length code
  output logic [7:0] line_format_o // whole format
);
  import uart_ifc_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  logic [7:0] enh;
  logic [1:0] rx_tsel;
  logic [1:0] tx_tsel;
  logic [1:0] rx_fl_cnt;
  logic [1:0] tx_fl_cnt;
  logic rx_flush;
  logic tx_flush;
  logic key;
  logic div;
  logic wr_hold;
  logic wr_setup;
  logic rd_hold;
  logic rd_src;
  logic rd_lstat;
  logic rd_mstat;
  logic rd_pins;
  logic [10:0] rx_head;
  logic rx_has;
  logic rx_in_rdy;
  logic rx_pop;
  logic [CW-1:0] rx_cnt;
  logic [7:0] tx_head;
  logic tx_has;
  logic tx_take;
  logic [CW-1:0] tx_cnt;
  logic overrun;
  logic [CW-1:0] err_cnt;
  logic [7:0] tout_cnt;
  logic [7:0] tout_lim;
  logic tout_flag;
  logic tx_flag;
  logic tx_cond;
  logic tx_cond_d;
  logic tx_empty;
  logic [7:0] tx_space;
  logic rx_lvl;
  logic [3:0] msr_delta;
  logic [GPIO_N-1:0] pin_s1;
  logic [GPIO_N-1:0] pin_s2;
  logic [GPIO_N-1:0] pin_d;
  logic pin_flag;
  logic cts_s1;
  logic cts_s2;
  logic cts_d;
  logic rts_d;
  logic xoff_flag;
  logic spch_flag;
  logic flow_flag;
  logic mask_tx_d;
  logic ls_p, to_p, rx_p, tx_p, ms_p, pin_p, xo_p, fl_p;
  logic [5:0] src;
  logic [7:0] next_rdata;

  assign key = line_format_o == ENH_KEY;
  assign div = line_format_o[FMT_DIV];
  assign wr_hold = reg_wr_i & reg_addr_i == ADDR_HOLD & ~div;
  assign wr_setup = reg_wr_i & reg_addr_i == ADDR_SRC & ~key;
  assign rd_hold = reg_rd_i & reg_addr_i == ADDR_HOLD & ~div;
  assign rd_src = reg_rd_i & reg_addr_i == ADDR_SRC & ~key;
  assign rd_lstat = reg_rd_i & reg_addr_i == ADDR_LSTAT;
  assign rd_mstat = reg_rd_i & reg_addr_i == ADDR_MSTAT;
  assign rd_pins = reg_rd_i & reg_addr_i == ADDR_PINS;
  assign rx_pop = rd_hold & rx_has;
  assign rx_flush = rx_fl_cnt != 2'h0;
  assign tx_flush = tx_fl_cnt != 2'h0;
  assign tx_take = ~tx_valid_o | tx_ready_i;
  assign word_len_o = line_format_o[1:0];

  uart_ifc_fifo #(.W(11), .DEPTH(DEPTH)) rx_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(rx_flush),
    .in_valid_i(rx_valid_i),
    .in_data_i({rx_err_i, rx_data_i}),
    .in_ready_o(rx_in_rdy),
    .out_valid_o(rx_has),
    .out_data_o(rx_head),
    .out_ready_i(rx_pop),
    .count_o(rx_cnt)
  );
  assign rx_ready_o = rx_in_rdy;

  uart_ifc_fifo #(.W(8), .DEPTH(DEPTH)) tx_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(tx_flush),
    .in_valid_i(wr_hold),
    .in_data_i(reg_wdata_i),
    .in_ready_o(thr_ready_o),
    .out_valid_o(tx_has),
    .out_data_o(tx_head),
    .out_ready_i(tx_take),
    .count_o(tx_cnt)
  );

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (tx_take) begin
      tx_valid_o <= tx_has;
      tx_data_o <= tx_head;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sleep_en_o <= 1'b0;
      enh <= ENH_RST;
      line_format_o <= FMT_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_MASK & ~div) begin
        if (enh[ENH_EN]) begin
          sleep_en_o <= reg_wdata_i[MASK_SLEEP];
        end
      end
      if (reg_addr_i == ADDR_SRC & key) begin
        enh <= reg_wdata_i;
      end
      if (reg_addr_i == ADDR_FMT) begin
        line_format_o <= reg_wdata_i;
      end
    end
  end

  logic [7:0] mask;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask <= MASK_RST;
    end else if (reg_wr_i & reg_addr_i == ADDR_MASK & ~div) begin
      mask[3:0] <= reg_wdata_i[3:0];
      if (enh[ENH_EN]) begin
        mask[7:4] <= reg_wdata_i[7:4];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_en_o <= 1'b0;
      rx_tsel <= 2'h0;
      tx_tsel <= 2'h0;
      rx_fl_cnt <= 2'h0;
      tx_fl_cnt <= 2'h0;
    end else begin
      if (rx_flush) begin
        rx_fl_cnt <= rx_fl_cnt - 2'h1;
      end
      if (tx_flush) begin
        tx_fl_cnt <= tx_fl_cnt - 2'h1;
      end
      if (wr_setup) begin
        fifo_en_o <= reg_wdata_i[SET_EN];
        if (reg_wdata_i[SET_EN]) begin
          rx_tsel <= reg_wdata_i[7:6];
          if (enh[ENH_EN]) begin
            tx_tsel <= reg_wdata_i[5:4];
          end
          if (reg_wdata_i[SET_RXRST]) begin
            rx_fl_cnt <= FLUSH_CYC;
          end
          if (reg_wdata_i[SET_TXRST]) begin
            tx_fl_cnt <= FLUSH_CYC;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i | rx_flush) begin
      err_cnt <= '0;
    end else if ((rx_valid_i & rx_in_rdy & |rx_err_i) !=
                 (rx_pop & |rx_head[10:8])) begin
      if (rx_pop & |rx_head[10:8]) begin
        err_cnt <= err_cnt - 1'b1;
      end else begin
        err_cnt <= err_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
    end else begin
      overrun <= (overrun & ~rd_lstat) | (rx_valid_i & ~rx_in_rdy);
    end
  end

  always_comb begin
    tout_lim = TOUT_CHARS * (FRAME_BASE + {6'h00, line_format_o[1:0]})
      + TOUT_BITS;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tout_cnt <= 8'h00;
      tout_flag <= 1'b0;
    end else if (~rx_has | rx_pop | (rx_valid_i & rx_in_rdy)) begin
      tout_cnt <= 8'h00;
      if (rd_hold) begin
        tout_flag <= 1'b0;
      end
    end else if (bit_tick_i & tout_cnt != tout_lim) begin
      tout_cnt <= tout_cnt + 8'h01;
      if (tout_cnt == tout_lim - 8'h01) begin
        tout_flag <= 1'b1;
      end
    end
  end

  always_comb begin
    if (fifo_en_o) begin
      rx_lvl = {{(8 - CW){1'b0}}, rx_cnt} >= {1'b0, RX_TRIG[rx_tsel]};
    end else begin
      rx_lvl = rx_has;
    end
  end

  always_comb begin
    tx_empty = ~tx_has & ~tx_valid_o;
    tx_space = 8'(DEPTH) - {{(8 - CW){1'b0}}, tx_cnt};
    if (fifo_en_o) begin
      tx_cond = tx_space > {1'b0, TX_TRIG[tx_tsel]};
    end else begin
      tx_cond = tx_empty;
    end
    tx_cond = tx_cond | (rs485_auto_i & tx_idle_i & tx_empty);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_cond_d <= 1'b0;
      mask_tx_d <= 1'b0;
      tx_flag <= 1'b0;
    end else begin
      tx_cond_d <= tx_cond;
      mask_tx_d <= mask[MASK_TX];
      tx_flag <= (tx_flag & ~wr_hold & ~(rd_src & src == SRC_TX))
        | (tx_cond & (~tx_cond_d | (mask[MASK_TX] & ~mask_tx_d)));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      msr_delta <= 4'h0;
      flow_flag <= 1'b0;
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
      cts_d <= 1'b0;
      rts_d <= 1'b0;
    end else begin
      cts_s1 <= cts_n_i;
      cts_s2 <= cts_s1;
      cts_d <= cts_s2;
      rts_d <= rts_n_i;
      msr_delta <= (rd_mstat ? 4'h0 : msr_delta) | modem_delta_i;
      flow_flag <= (flow_flag & ~rd_mstat)
        | (cts_s2 & ~cts_d & mask[MASK_CTS] & enh[ENH_ACTS])
        | (rts_n_i & ~rts_d & mask[MASK_RTS] & enh[ENH_ARTS]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
      pin_flag <= 1'b0;
    end else begin
      pin_s1 <= gpio_i;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      pin_flag <= (pin_flag & ~rd_pins) | (pin_s2 != pin_d);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      xoff_flag <= 1'b0;
      spch_flag <= 1'b0;
    end else begin
      xoff_flag <= (xoff_flag & ~xon_det_i)
        | (xoff_det_i & enh[ENH_EN] & mask[MASK_XOFF]);
      spch_flag <= (spch_flag & ~(rd_src & src == SRC_XOFF))
        | (spchar_det_i & enh[ENH_EN] & mask[MASK_XOFF]);
    end
  end

  assign ls_p = mask[MASK_LS] & (overrun | err_cnt != '0);
  assign to_p = mask[MASK_RX] & tout_flag;
  assign rx_p = mask[MASK_RX] & rx_lvl;
  assign tx_p = mask[MASK_TX] & tx_flag;
  assign ms_p = mask[MASK_MS] & |msr_delta;
  assign pin_p = pin_flag;
  assign xo_p = enh[ENH_EN] & mask[MASK_XOFF] & (xoff_flag | spch_flag);
  assign fl_p = enh[ENH_EN] & flow_flag;

  always_comb begin
    if (ls_p) begin
      src = SRC_LS;
    end else if (to_p) begin
      src = SRC_TOUT;
    end else if (rx_p) begin
      src = SRC_RX;
    end else if (tx_p) begin
      src = SRC_TX;
    end else if (ms_p) begin
      src = SRC_MS;
    end else if (pin_p) begin
      src = SRC_PIN;
    end else if (xo_p) begin
      src = SRC_XOFF;
    end else if (fl_p) begin
      src = SRC_FLOW;
    end else begin
      src = SRC_NONE;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      ADDR_HOLD: next_rdata = div ? 8'h00 : rx_head[7:0];
      ADDR_MASK: next_rdata = div ? 8'h00 : mask;
      ADDR_SRC: next_rdata = key ? enh : {{2{fifo_en_o}}, src};
      ADDR_FMT: next_rdata = line_format_o;
      ADDR_LSTAT: next_rdata = {err_cnt != '0, tx_empty & tx_idle_i,
        tx_empty, rx_head[10:8] & {3{rx_has}}, overrun, rx_has};
      ADDR_MSTAT: next_rdata = {modem_lines_i, msr_delta};
      ADDR_PINS: next_rdata = {{(8 - GPIO_N){1'b0}}, pin_s2};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_flush_run;
    rx_flush [*3] ##1 !rx_flush;
  endsequence
  property p_sleep_lock;
    reg_wr_i & reg_addr_i == ADDR_MASK & ~enh[ENH_EN] |=> $stable(sleep_en_o);
  endproperty
  a_sleep_lock: assert property (p_sleep_lock)
    else $error("sleep bit changed without enhanced enable");
  property p_xoff_lock;
    reg_wr_i & reg_addr_i == ADDR_MASK & ~enh[ENH_EN] |=> $stable(mask[7:5]);
  endproperty
  a_xoff_lock: assert property (p_xoff_lock)
    else $error("upper mask bits changed without enhanced enable");
  property p_ls_code;
    rd_src & ls_p |=> reg_rdata_o[5:0] == SRC_LS;
  endproperty
  a_ls_code: assert property (p_ls_code)
    else $error("line status not reported first");
  property p_idle_code;
    rd_src & !(ls_p | to_p | rx_p | tx_p | ms_p | pin_p | xo_p | fl_p)
      |=> reg_rdata_o[5:0] == SRC_NONE;
  endproperty
  a_idle_code: assert property (p_idle_code)
    else $error("idle source code wrong");
  property p_fifo_bits;
    rd_src |=> reg_rdata_o[7:6] == {2{$past(fifo_en_o)}};
  endproperty
  a_fifo_bits: assert property (p_fifo_bits)
    else $error("FIFO state bits wrong");
  property p_setup_ignore;
    wr_setup & ~reg_wdata_i[SET_EN] |=> $stable(rx_tsel) & !rx_flush;
  endproperty
  a_setup_ignore: assert property (p_setup_ignore)
    else $error("setup bits taken with enable clear");
  property p_flush;
    wr_setup & reg_wdata_i[SET_EN] & reg_wdata_i[SET_RXRST] |=> s_flush_run;
  endproperty
  a_flush: assert property (p_flush)
    else $error("receive flush not three clocks");
  property p_tx_clear;
    wr_hold & ~tx_cond |=> !tx_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("transmit ready not cleared by write");
  property p_xon_clear;
    xon_det_i & ~xoff_det_i |=> !xoff_flag;
  endproperty
  a_xon_clear: assert property (p_xon_clear)
    else $error("Xoff not cleared by Xon");
  property p_wlen;
    reg_wr_i & reg_addr_i == ADDR_FMT |=> word_len_o == $past(reg_wdata_i[1:0]);
  endproperty
  a_wlen: assert property (p_wlen)
    else $error("word length not updated");
endmodule : uart_ifc

// [hdl/uart_ifc_pkg.sv]
// Contract
// - Mask bit 4 enables sleep; writable only with enhanced features on.
// - Mask bit 5 enables received Xoff interrupt; needs enhanced features.
// - Mask bits 6,7 enable RTS/CTS low-to-high interrupts; need enhanced.
// - Source read shows only the highest pending level; others stay queued.
// - Levels 1-5 encode 000110, 001100, 000100, 000010, 000000.
// - Level 7 is 010000, level 8 is 100000, nothing pending 000001.
// - Source bit 0 reads 0 while pending, 1 when idle; resets to 1.
// - Line status pending on error bits; clears when errored chars drain.
// - Receive timeout after four characters plus 12 bits; clears on read.
// - Receive ready at trigger level; clears when fill drops below it.
// - Transmit ready on empty, spaces above trigger or RS-485 idle.
// - Modem status pending on delta bits 0-3; clears on status read.
// - General input toggle raises interrupt; clears on pin state read.
// - Source bit 4 flags Xoff or special char; Xon clears Xoff, source read clears special char.
// - Source bit 5 flags flow-control change; clears on modem read.
// - Source bits 7:6 read 11 with FIFOs enabled, 00 when disabled.
// - Setup bit 0 enables FIFOs; other bits ignored unless it is 1.
// - Setup bits 1,2 flush receive or transmit FIFO for 3 clocks.
// - Setup bit 3 has no effect.
// - Setup bits 5:4 pick transmit trigger 8,16,32,56; need enhanced.
// - Setup bits 7:6 pick receive trigger 8,16,56,60.
// - Format bits 1:0 pick word length 5 to 8, default 6.
package uart_ifc_pkg;
  localparam logic [3:0] ADDR_HOLD = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_SRC = 4'h2;
  localparam logic [3:0] ADDR_FMT = 4'h3;
  localparam logic [3:0] ADDR_LSTAT = 4'h5;
  localparam logic [3:0] ADDR_MSTAT = 4'h6;
  localparam logic [3:0] ADDR_PINS = 4'hB;
  localparam logic [7:0] ENH_KEY = 8'hBF;
  localparam logic [7:0] FMT_RST = 8'h1D;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ENH_RST = 8'h00;
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LS = 2;
  localparam int MASK_MS = 3;
  localparam int MASK_SLEEP = 4;
  localparam int MASK_XOFF = 5;
  localparam int MASK_RTS = 6;
  localparam int MASK_CTS = 7;
  localparam int ENH_EN = 4;
  localparam int ENH_ARTS = 6;
  localparam int ENH_ACTS = 7;
  localparam int FMT_DIV = 7;
  localparam int SET_EN = 0;
  localparam int SET_RXRST = 1;
  localparam int SET_TXRST = 2;
  localparam logic [5:0] SRC_LS = 6'h06;
  localparam logic [5:0] SRC_TOUT = 6'h0C;
  localparam logic [5:0] SRC_RX = 6'h04;
  localparam logic [5:0] SRC_TX = 6'h02;
  localparam logic [5:0] SRC_MS = 6'h00;
  localparam logic [5:0] SRC_PIN = 6'h30;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam logic [6:0] TX_TRIG [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  localparam logic [6:0] RX_TRIG [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  localparam logic [1:0] FLUSH_CYC = 2'h3;
  localparam logic [7:0] TOUT_CHARS = 8'h04;
  localparam logic [7:0] TOUT_BITS = 8'h0C;
  localparam logic [7:0] FRAME_BASE = 8'h07;
endpackage : uart_ifc_pkg

// [test/serial_side_model.sv]
`timescale 1ns/100ps
module serial_side_model (
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic stall_i, // hold off transmitter
  input wire logic slow_i, // accept one in four
  input wire logic [7:0] tx_data_i, // char offered
  input wire logic tx_valid_i, // offer valid
  output logic tx_ready_o, // char taken
  output logic tx_idle_o // shifter empty
);
  logic [7:0] got [$];
  logic [1:0] phase;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign tx_ready_o = !stall_i && (!slow_i || phase == 2'h3);
  assign tx_idle_o = !tx_valid_i;
  always @(posedge sys_clk_i) begin
    if (!rst_i && tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
    end
  end
endmodule : serial_side_model

// [test/uart_interrupt_fifo_control_tb.sv]
`timescale 1ns/100ps
module uart_interrupt_fifo_control_tb;
  import uart_ifc_pkg::*;
  localparam int FDEPTH = 32;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [3:0] addr = 4'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic rxv = 1'h0;
  logic tick = 1'h0;
  logic stall = 1'h1;
  logic slow = 1'h0;
  logic xoff = 1'h0;
  logic xon = 1'h0;
  logic spc = 1'h0;
  logic [3:0] mln = 4'h0;
  logic fen_exp = 1'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rxd = 8'h00;
  logic [2:0] rxe = 3'h0;
  logic [3:0] mdl = 4'h0;
  logic [3:0] gpio = 4'h0;
  logic [7:0] rdata, txd, rv, v;
  logic rvalid, rxr, txv, txr, idle, tx_holding, sleep, fen;
  logic [1:0] wl;
  logic [7:0] lf;
  logic [31:0] seed = 32'h459776B1;
  logic [7:0] q [$];
  logic [7:0] tq [$];
  int n_fail = 0;
  int tests_run = 0;
  int n;

  uart_ifc #(.DEPTH(FDEPTH), .GPIO_N(4)) uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .rx_data_i(rxd),
    .rx_err_i(rxe), .rx_valid_i(rxv), .rx_ready_o(rxr),
    .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr),
    .tx_idle_i(idle), .thr_ready_o(tx_holding), .rs485_auto_i(1'h0),
    .bit_tick_i(tick), .modem_lines_i(mln), .modem_delta_i(mdl),
    .cts_n_i(1'h0), .rts_n_i(1'h0), .gpio_i(gpio), .xoff_det_i(xoff),
    .xon_det_i(xon), .spchar_det_i(spc), .sleep_en_o(sleep),
    .fifo_en_o(fen), .word_len_o(wl), .line_format_o(lf));

  serial_side_model line (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
    .slow_i(slow), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_ready_o(txr), .tx_idle_o(idle));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  function automatic logic [7:0] src_exp(input logic [5:0] c);
    return {fen_exp, fen_exp, c};
  endfunction : src_exp

  function automatic int tout_limit(input logic [1:0] c);
    return 4 * (int'(c) + 5 + 2) + 12;
  endfunction : tout_limit

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk_i);
    wr <= 1'h0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk_i);
    rd <= 1'h0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask : rd_reg

  task automatic src_is(input logic [5:0] c);
    rd_reg(ADDR_SRC, rv);
    chk(rv, src_exp(c));
  endtask : src_is

  task automatic push(input logic [7:0] d, input logic [2:0] e);
    @(posedge sys_clk_i);
    rxd <= d;
    rxe <= e;
    rxv <= 1'h1;
    @(posedge sys_clk_i);
    rxv <= 1'h0;
    q.push_back(d);
    @(posedge sys_clk_i);
    #1;
  endtask : push

  task automatic pop;
    rd_reg(ADDR_HOLD, rv);
    chk(rv, q.pop_front());
  endtask : pop

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge sys_clk_i);
      tick <= 1'h1;
      @(posedge sys_clk_i);
      tick <= 1'h0;
    end
  endtask : ticks

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    mln <= 4'($random(seed));
    src_is(SRC_NONE);
    rd_reg(ADDR_FMT, rv);
    chk(rv, FMT_RST);
    rd_reg(ADDR_MASK, rv);
    chk(rv, MASK_RST);
    for (int i = 0; i < 4; i++) begin
      v = 8'(i) | (8'($random(seed)) & 8'h7C);
      wr_reg(ADDR_FMT, v);
      chk({6'h00, wl}, 8'(i));
      chk(lf, v);
    end
    // Enhanced bits locked until enabled
    wr_reg(ADDR_MASK, 8'hFF);
    rd_reg(ADDR_MASK, rv);
    chk(rv, 8'h0F);
    chk({7'h00, sleep}, 8'h00);
    wr_reg(ADDR_FMT, ENH_KEY);
    wr_reg(ADDR_SRC, 8'h10);
    wr_reg(ADDR_FMT, 8'h03);
    wr_reg(ADDR_MASK, 8'hF0);
    rd_reg(ADDR_MASK, rv);
    chk(rv, 8'hF0);
    chk({7'h00, sleep}, 8'h01);
    wr_reg(ADDR_SRC, 8'h01);
    fen_exp = 1'h1;
    chk({7'h00, fen}, 8'h01);
    src_is(SRC_NONE);
    @(posedge sys_clk_i);
    xoff <= 1'h1;
    @(posedge sys_clk_i);
    xoff <= 1'h0;
    src_is(SRC_XOFF);
    src_is(SRC_XOFF);
    @(posedge sys_clk_i);
    xon <= 1'h1;
    @(posedge sys_clk_i);
    xon <= 1'h0;
    src_is(SRC_NONE);
    // Special character cleared by the source read
    @(posedge sys_clk_i);
    spc <= 1'h1;
    @(posedge sys_clk_i);
    spc <= 1'h0;
    src_is(SRC_XOFF);
    src_is(SRC_NONE);
    wr_reg(ADDR_MASK, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      mdl <= 4'h1 << i;
      @(posedge sys_clk_i);
      mdl <= 4'h0;
      src_is(SRC_MS);
      rd_reg(ADDR_MSTAT, rv);
      chk(rv, {mln, 4'(1 << i)});
      src_is(SRC_NONE);
    end
    @(posedge sys_clk_i);
    gpio <= 4'h5;
    repeat (4) @(posedge sys_clk_i);
    src_is(SRC_PIN);
    rd_reg(ADDR_PINS, rv);
    chk(rv, 8'h05);
    src_is(SRC_NONE);
    wr_reg(ADDR_MASK, 8'h02);
    src_is(SRC_TX);
    src_is(SRC_NONE);
    wr_reg(ADDR_MASK, 8'h01);
    repeat (7) push(8'($random(seed)), 3'h0);
    src_is(SRC_NONE);
    push(8'($random(seed)), 3'h0);
    src_is(SRC_RX);
    pop();
    src_is(SRC_NONE);
    ticks(tout_limit(wl) - 2);
    src_is(SRC_NONE);
    ticks(3);
    src_is(SRC_TOUT);
    pop();
    src_is(SRC_NONE);
    wr_reg(ADDR_MASK, 8'h05);
    push(8'($random(seed)), 3'h1);
    src_is(SRC_LS);
    push(8'($random(seed)), 3'h0);
    src_is(SRC_LS);
    repeat (6) pop();
    src_is(SRC_LS);
    pop();
    src_is(SRC_NONE);
    wr_reg(ADDR_SRC, 8'h03);
    repeat (4) @(posedge sys_clk_i);
    q.delete();
    rd_reg(ADDR_LSTAT, rv);
    chk(rv & 8'h01, 8'h00);
    // Fill receive buffer until refused, then drain
    wr_reg(ADDR_MASK, 8'h00);
    n = 0;
    while (rxr === 1'h1 && n < 40) begin
      push(8'($random(seed)), 3'h0);
      n++;
    end
    chk(8'(n), 8'(FDEPTH));
    repeat (n) pop();
    rd_reg(ADDR_LSTAT, rv);
    chk(rv & 8'h01, 8'h00);
    // Transmit side stalled until the buffer refuses
    n = 0;
    while (tx_holding === 1'h1 && n < 40) begin
      v = 8'($random(seed));
      tq.push_back(v);
      wr_reg(ADDR_HOLD, v);
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({7'h00, n >= FDEPTH}, 8'h01);
    @(posedge sys_clk_i);
    slow <= 1'h1;
    stall <= 1'h0;
    for (int k = 0; k < 2000 && line.got.size() < n; k++) begin
      @(posedge sys_clk_i);
    end
    chk(8'(line.got.size()), 8'(n));
    foreach (line.got[i]) chk(line.got[i], tq[i]);
    // Enable clear: FIFOs off, other setup bits ignored
    wr_reg(ADDR_SRC, 8'hC0);
    fen_exp = 1'h0;
    chk({7'h00, fen}, 8'h00);
    src_is(SRC_NONE);
    close_out();
  end
endmodule : uart_interrupt_fifo_control_tb
